// ==== rtl/talb_pkg.sv ====
// shared constants and types for the trailer alert lamp blinker
package talb_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // power-up blink window, minutes
  localparam int unsigned BLINK_WINDOW_MIN = 1;
  localparam longint unsigned BLINK_WINDOW_CYC = longint'(BLINK_WINDOW_MIN) * 60 * CLK_HZ;
  // sensor silence before trouble, minutes
  localparam int unsigned SENSOR_SILENCE_MIN = 35;
  localparam longint unsigned SENSOR_SILENCE_CYC = longint'(SENSOR_SILENCE_MIN) * 60 * CLK_HZ;
  // blink timing, milliseconds
  localparam int unsigned BLINK_ON_MS = 300;
  localparam int unsigned BLINK_OFF_MS = 300;
  localparam int unsigned BLINK_GAP_MS = 2000;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // default critical low margin, percent under target
  localparam int unsigned CRIT_LOW_PCT_DEF = 20;
  localparam int unsigned PCT_FULL = 100;
  // blink counts per condition
  localparam logic [2:0] BLINKS_HIGH_TEMP = 3'h5;
  localparam logic [2:0] BLINKS_CRIT_LOW = 3'h4;
  localparam logic [2:0] BLINKS_SETUP = 3'h3;
  localparam logic [2:0] BLINKS_MINOR = 3'h2;
  localparam logic [2:0] BLINKS_SENSOR = 3'h1;
  localparam logic [2:0] BLINKS_NONE = 3'h0;
  // temperature limit in degrees C
  localparam logic [7:0] HIGH_TEMP_C = 8'h55;
  typedef enum logic [1:0] {
    TALB_IDLE,
    TALB_ON,
    TALB_OFF,
    TALB_GAP
  } talb_phase_t;
endpackage

// ==== rtl/talb_timer.sv ====
// down-counting timer that pulses once when its load expires
`timescale 1ns/1ps
module talb_timer #(
  parameter int W = 40
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic expired;
  } talb_tmr_t;
  talb_tmr_t s_reg;
  talb_tmr_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.expired = 1'b0;
    if (i_load) begin
      s_next.cnt = i_count;
      s_next.run = 1'b1;
    end else if (s_reg.run) begin
      if (s_reg.cnt <= W'(1)) begin
        s_next.run = 1'b0;
        s_next.expired = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_expired = s_reg.expired;
endmodule

// ==== rtl/talb_lamp.sv ====
// trailer warning lamp driver: blink code after power-up, steady level afterwards
//
// Notes on behaviour
// - first minute after power-up repeat blink code; afterwards lamp steady on or off
// - air temperature above 85C gives five blinks, then lamp held on
// - pressure below critical low (default 20% under target) gives four blinks, then on
// - minor over or under pressure gives two blinks, then lamp off
// - no sensor data for 35 minutes raises trouble; one blink, then off
// - missing or invalid stored configuration raises trouble; three blinks, then off
// - thresholds come from own stored settings; tow vehicle levels never replace them
`timescale 1ns/1ps
module talb_lamp #(
  parameter int NUM_TIRES = 8,
  parameter longint unsigned WINDOW_CYC = talb_pkg::BLINK_WINDOW_CYC,
  parameter longint unsigned SILENCE_CYC = talb_pkg::SENSOR_SILENCE_CYC,
  parameter int unsigned ON_CYC = talb_pkg::BLINK_ON_MS * talb_pkg::MS_CYC,
  parameter int unsigned OFF_CYC = talb_pkg::BLINK_OFF_MS * talb_pkg::MS_CYC,
  parameter int unsigned GAP_CYC = talb_pkg::BLINK_GAP_MS * talb_pkg::MS_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [NUM_TIRES-1:0] i_tire_rx,
  input wire logic [NUM_TIRES*8-1:0] i_tire_temp_c,
  input wire logic [NUM_TIRES*12-1:0] i_tire_press,
  input wire logic [NUM_TIRES*12-1:0] i_tire_target,
  input wire logic [6:0] i_crit_low_pct,
  input wire logic [6:0] i_minor_pct,
  input wire logic i_cfg_valid,
  output logic o_lamp,
  output logic [2:0] o_code,
  output logic o_window
);
  localparam int TW = 40;
  localparam int BW = 32;

  typedef struct packed {
    logic [TW-1:0] window_cnt;
    logic window;
    logic [NUM_TIRES-1:0] seen;
    logic [NUM_TIRES-1:0] high_temp;
    logic [NUM_TIRES-1:0] crit_low;
    logic [NUM_TIRES-1:0] minor;
    logic [2:0] code;
    logic [2:0] blinks_left;
    logic [BW-1:0] phase_cnt;
    talb_pkg::talb_phase_t phase;
    logic lamp;
    logic setup_bad;
    logic armed;
  } talb_state_t;
  talb_state_t s_reg;
  talb_state_t s_next;

  // reception strobes and config-valid pass two flip-flops; readings and margins are used directly
  logic [NUM_TIRES-1:0] rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic cfg_meta_reg, cfg_sync_reg;
  logic [NUM_TIRES-1:0] silent;
  logic [NUM_TIRES-1:0] silent_hold;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rx_meta_reg <= '0;
      rx_sync_reg <= '0;
      rx_prev_reg <= '0;
      // reset to the valid level so setup trouble never flashes right after reset
      cfg_meta_reg <= 1'b1;
      cfg_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= i_tire_rx;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
      cfg_meta_reg <= i_cfg_valid;
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  // one silence timer per tire, reloaded on each reception and at power-up
  genvar g;
  generate
    for (g = 0; g < NUM_TIRES; g++) begin : g_tire
      logic rx_pulse;
      logic [TW-1:0] silence_load;
      // a single load at reset release, so a tire that never reports still times out
      assign rx_pulse = (rx_sync_reg[g] & ~rx_prev_reg[g]) | ~s_reg.armed;
      assign silence_load = TW'(SILENCE_CYC);
      talb_timer #(.W(TW)) u_silence (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_load(rx_pulse),
        .i_count(silence_load),
        .o_expired(silent[g])
      );
    end
  endgenerate

  // threshold compare against locally stored settings only
  function automatic logic below_pct(input logic [11:0] p, input logic [11:0] t, input logic [6:0] pct);
    logic [20:0] lhs;
    logic [20:0] rhs;
    lhs = 21'(p) * 21'(talb_pkg::PCT_FULL);
    rhs = 21'(t) * 21'(7'(talb_pkg::PCT_FULL) - pct);
    return lhs < rhs;
  endfunction

  function automatic logic above_pct(input logic [11:0] p, input logic [11:0] t, input logic [6:0] pct);
    logic [20:0] lhs;
    logic [20:0] rhs;
    lhs = 21'(p) * 21'(talb_pkg::PCT_FULL);
    rhs = 21'(t) * 21'(8'(talb_pkg::PCT_FULL) + 8'(pct));
    return lhs > rhs;
  endfunction

  logic [6:0] crit_pct;
  assign crit_pct = (i_crit_low_pct == 7'h00) ? 7'(talb_pkg::CRIT_LOW_PCT_DEF) : i_crit_low_pct;

  always_comb begin
    logic [2:0] want;
    logic ending;
    s_next = s_reg;
    want = talb_pkg::BLINKS_NONE;
    ending = 1'b0;
    s_next.armed = 1'b1;
    s_next.setup_bad = ~cfg_sync_reg;
    for (int i = 0; i < NUM_TIRES; i++) begin
      if (rx_sync_reg[i] & ~rx_prev_reg[i]) begin
        s_next.seen[i] = 1'b1;
        s_next.high_temp[i] = i_tire_temp_c[i*8 +: 8] > talb_pkg::HIGH_TEMP_C;
        s_next.crit_low[i] = below_pct(i_tire_press[i*12 +: 12], i_tire_target[i*12 +: 12], crit_pct);
        s_next.minor[i] = below_pct(i_tire_press[i*12 +: 12], i_tire_target[i*12 +: 12], i_minor_pct)
          | above_pct(i_tire_press[i*12 +: 12], i_tire_target[i*12 +: 12], i_minor_pct);
      end
      // silence expiry keeps the last reading but flags trouble
    end
    // most severe first
    if (|s_reg.high_temp) begin
      want = talb_pkg::BLINKS_HIGH_TEMP;
    end else if (|s_reg.crit_low) begin
      want = talb_pkg::BLINKS_CRIT_LOW;
    end else if (s_reg.setup_bad) begin
      want = talb_pkg::BLINKS_SETUP;
    end else if (|s_reg.minor) begin
      want = talb_pkg::BLINKS_MINOR;
    end else if (|silent_hold) begin
      want = talb_pkg::BLINKS_SENSOR;
    end
    s_next.code = want;
    // one-minute window from reset release
    if (s_reg.window) begin
      if (s_reg.window_cnt >= TW'(WINDOW_CYC - 1)) begin
        s_next.window = 1'b0;
        ending = 1'b1;
      end else begin
        s_next.window_cnt = s_reg.window_cnt + TW'(1);
      end
    end
    if (!s_reg.window || ending) begin
      s_next.phase = talb_pkg::TALB_IDLE;
      // steady: on only for the two severe codes
      s_next.lamp = (want == talb_pkg::BLINKS_HIGH_TEMP) || (want == talb_pkg::BLINKS_CRIT_LOW);
    end else begin
      // a code change takes effect at the next repetition; only the end of the window cuts a pattern short
      case (s_reg.phase)
        talb_pkg::TALB_IDLE: begin
          s_next.lamp = 1'b0;
          if (want != talb_pkg::BLINKS_NONE) begin
            s_next.blinks_left = want;
            s_next.phase = talb_pkg::TALB_ON;
            s_next.phase_cnt = BW'(ON_CYC - 1);
            s_next.lamp = 1'b1;
          end
        end
        talb_pkg::TALB_ON: begin
          if (s_reg.phase_cnt == '0) begin
            s_next.lamp = 1'b0;
            s_next.blinks_left = s_reg.blinks_left - 3'h1;
            if (s_reg.blinks_left == 3'h1) begin
              s_next.phase = talb_pkg::TALB_GAP;
              s_next.phase_cnt = BW'(GAP_CYC - 1);
            end else begin
              s_next.phase = talb_pkg::TALB_OFF;
              s_next.phase_cnt = BW'(OFF_CYC - 1);
            end
          end else begin
            s_next.phase_cnt = s_reg.phase_cnt - BW'(1);
          end
        end
        talb_pkg::TALB_OFF: begin
          if (s_reg.phase_cnt == '0) begin
            s_next.phase = talb_pkg::TALB_ON;
            s_next.phase_cnt = BW'(ON_CYC - 1);
            s_next.lamp = 1'b1;
          end else begin
            s_next.phase_cnt = s_reg.phase_cnt - BW'(1);
          end
        end
        default: begin
          if (s_reg.phase_cnt == '0) begin
            s_next.phase = talb_pkg::TALB_IDLE;
          end else begin
            s_next.phase_cnt = s_reg.phase_cnt - BW'(1);
          end
        end
      endcase
    end
  end

  // silence flag per tire: set by expiry, cleared by next reception; set wins
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      silent_hold <= '0;
    end else begin
      silent_hold <= silent | (silent_hold & ~(rx_sync_reg & ~rx_prev_reg));
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_reg <= '0;
      s_reg.window <= 1'b1;
      s_reg.phase <= talb_pkg::TALB_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_lamp = s_reg.lamp;
  assign o_code = s_reg.code;
  assign o_window = s_reg.window;
endmodule

// ==== verif/talb_lamp_assertions.sv ====
// concurrent checks on the lamp blinker ports
`timescale 1ns/1ps
module talb_lamp_assertions #(
  parameter int NUM_TIRES = 8,
  parameter longint unsigned WINDOW_CYC = talb_pkg::BLINK_WINDOW_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [NUM_TIRES-1:0] i_tire_rx,
  input wire logic [NUM_TIRES*8-1:0] i_tire_temp_c,
  input wire logic i_cfg_valid,
  input wire logic o_lamp,
  input wire logic [2:0] o_code,
  input wire logic o_window
);
  logic [63:0] win_cnt_reg;
  logic hot;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      win_cnt_reg <= 64'h0;
    end else if (o_window) begin
      win_cnt_reg <= win_cnt_reg + 64'h1;
    end
  end
  always_comb begin
    hot = 1'b0;
    for (int t = 0; t < NUM_TIRES; t++) begin
      hot = hot | (i_tire_temp_c[t*8+:8] > 8'h55);
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence s_lit5;
    (o_lamp || !o_window) [*5];
  endsequence
  sequence s_dark5;
    (!o_lamp || !o_window) [*5];
  endsequence
  sequence s_hot_report;
    $rose(|i_tire_rx) && hot;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) i_srst |=> !o_lamp && o_code == 3'h0 && o_window)
    else $error("outputs not cleared by reset");
  a_window_len: assert property ($fell(o_window) |-> win_cnt_reg + 64'h2 >= WINDOW_CYC && win_cnt_reg <= WINDOW_CYC + 64'h2)
    else $error("blink window length wrong");
  a_window_once: assert property (!o_window |=> !o_window)
    else $error("blink window reopened without reset");
  a_steady_on: assert property (!o_window && $past(!o_window) && $stable(o_code) && o_code inside {3'h4, 3'h5} |-> o_lamp)
    else $error("lamp not held on for severe code");
  a_steady_off: assert property (!o_window && $past(!o_window) && $stable(o_code) && o_code < 3'h4 |-> !o_lamp)
    else $error("lamp not off for mild code");
  a_blink_on: assert property ($rose(o_lamp) && o_window |-> s_lit5)
    else $error("blink on time too short");
  a_blink_off: assert property ($fell(o_lamp) && o_window |-> s_dark5)
    else $error("blink off time too short");
  a_temp_code: assert property (s_hot_report |-> ##[1:10] o_code == 3'h5)
    else $error("hot tire not shown as top code");
  a_setup_code: assert property (!i_cfg_valid [*8] |-> o_code >= 3'h3)
    else $error("setup trouble not shown");
endmodule
bind talb_lamp talb_lamp_assertions #(.NUM_TIRES(NUM_TIRES), .WINDOW_CYC(WINDOW_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_tire_rx(i_tire_rx), .i_tire_temp_c(i_tire_temp_c),
  .i_cfg_valid(i_cfg_valid), .o_lamp(o_lamp), .o_code(o_code), .o_window(o_window));

// ==== verif/talb_lamp_model.sv ====
// warning lamp model: counts the blinks of each repetition, reports them once the lamp has been dark for DARK_CYC cycles
`timescale 1ns/1ps
module talb_lamp_model #(
  parameter int DARK_CYC = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_lamp,
  output logic o_done,
  output logic [2:0] o_blinks
);
  logic [2:0] cnt = 3'h0;
  logic last = 1'b0;
  int dark = 0;
  initial o_done = 1'b0;
  // dark span longer than the off time but shorter than the gap marks a repetition end
  always @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    last <= i_lamp;
    dark <= i_lamp ? 0 : dark + 1;
    if (i_lamp && !last) begin
      cnt <= cnt + 3'h1;
    end
    if (dark == DARK_CYC && cnt != 3'h0) begin
      o_done <= 1'b1;
      o_blinks <= cnt;
      cnt <= 3'h0;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// testbench: each lamp condition through the blink window and the steady phase
`timescale 1ns/1ps
module tb_top;
  localparam int WIN = 3000;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_tire_rx = 8'h00;
  logic [63:0] i_tire_temp_c = 64'h0;
  logic [95:0] i_tire_press = 96'h0;
  logic [95:0] i_tire_target = 96'h0;
  logic [6:0] i_crit_low_pct = 7'h00;
  logic [6:0] i_minor_pct = 7'h0A;
  logic i_cfg_valid = 1'b1;
  logic quiet = 1'b0;
  logic o_lamp, o_window, done;
  logic [2:0] o_code, blinks;
  logic [2:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  // hot temp, pressure, critical margin, config valid, silent, expected code
  logic [11:0] tbl [8][6] = '{'{12'h056, 12'h2BC, 12'h000, 12'h000, 12'h000, 12'h005},
    '{12'h032, 12'h2BC, 12'h000, 12'h000, 12'h000, 12'h004}, '{12'h032, 12'h47E, 12'h000, 12'h000, 12'h000, 12'h003},
    '{12'h032, 12'h352, 12'h000, 12'h001, 12'h000, 12'h002}, '{12'h032, 12'h2BC, 12'h028, 12'h001, 12'h000, 12'h002},
    '{12'h032, 12'h47E, 12'h000, 12'h001, 12'h000, 12'h002},
    '{12'h032, 12'h3E8, 12'h000, 12'h001, 12'h001, 12'h001}, '{12'h032, 12'h3E8, 12'h000, 12'h001, 12'h000, 12'h000}};
  talb_lamp #(.WINDOW_CYC(WIN), .SILENCE_CYC(1000), .ON_CYC(5), .OFF_CYC(5), .GAP_CYC(20)) uut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_tire_rx(i_tire_rx), .i_tire_temp_c(i_tire_temp_c),
    .i_tire_press(i_tire_press), .i_tire_target(i_tire_target), .i_crit_low_pct(i_crit_low_pct),
    .i_minor_pct(i_minor_pct), .i_cfg_valid(i_cfg_valid), .o_lamp(o_lamp), .o_code(o_code), .o_window(o_window));
  talb_lamp_model lamp (.i_ref_clk(i_ref_clk), .i_lamp(o_lamp), .o_done(done), .o_blinks(blinks));
  always #5 i_ref_clk = ~i_ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // sensors report every 103 cycles unless silenced
  always begin
    repeat (100) @(negedge i_ref_clk);
    if (!quiet) i_tire_rx = 8'hFF;
    repeat (3) @(negedge i_ref_clk);
    i_tire_rx = 8'h00;
  end
  always @(negedge i_ref_clk) begin
    if (done === 1'b1 && exp_q.size() > 0) check(32'(blinks), 32'(exp_q.pop_front()));
  end
  initial begin
    int k;
    k = $urandom(14);
    for (int s = 0; s < 8; s++) begin
      @(negedge i_ref_clk);
      k = $urandom % 8;
      for (int t = 0; t < 8; t++) begin
        i_tire_temp_c[t*8+:8] = (t == k) ? tbl[s][0][7:0] : 8'h32;
        i_tire_press[t*12+:12] = (t == k) ? tbl[s][1] : 12'h3E8;
        i_tire_target[t*12+:12] = 12'h3E8;
      end
      i_crit_low_pct = tbl[s][2][6:0];
      i_cfg_valid = ~tbl[s][3][0] ? 1'b0 : 1'b1;
      quiet = tbl[s][4][0];
      i_srst = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      i_srst = 1'b0;
      @(negedge i_ref_clk);
      check(32'(o_window), 32'h1);
      // silence needs the full timeout before its code settles
      repeat (quiet ? 1500 : 400) @(negedge i_ref_clk);
      if (tbl[s][5] != 12'h000) exp_q.push_back(tbl[s][5][2:0]);
      repeat (WIN) @(negedge i_ref_clk);
      check(32'(o_window), 32'h0);
      check(32'(o_code), 32'(tbl[s][5]));
      check(32'(o_lamp), 32'(tbl[s][5] >= 12'h004));
      check(32'(exp_q.size()), 32'h0);
    end
    complete_run();
  end
  initial begin
    repeat (60000) @(negedge i_ref_clk);
    err_count++;
    complete_run();
  end
endmodule
